// file: rtl/bfc_pkg.sv
// constants and helpers for the brightness feature control/status register
// assumes APB access with 32-bit data; field bit 0 is the MSB of the word
//
// How it works
// [R01] presence flag (bit 0) always reads 1; writes do nothing.
// [R02] absolute-control flag (bit 1) always reads 0; writes do nothing.
// [R03] single-adjustment flag (bit 5) always reads 0; writing triggers nothing.
// [R04] enable flag (bit 6) always reads 1; writes cannot disable.
// [R05] auto/manual flag (bit 7) always reads 0, manual; writes ignored.
// [R06] level in bits 20-31, range 0..255, resets to 8; out-of-range writes dropped.
// [R07] 8-bit output: pixel rises one per four steps of level.
// [R08] 16-bit output: pixel rises one per one step of level.
// [R09] reserved bits 2-4 and 8-19 read zero; bit 0 is word MSB.
package bfc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // map
   localparam logic [11:0] BFC_BRIGHT_OFF = 12'h800;

   ////////////////////////////////////////////////////////////////////////////
   // field positions as lsb-0 indices of the 32-bit word
   localparam int BFC_PRES_POS  = 31;
   localparam int BFC_ABS_POS   = 30;
   localparam int BFC_PUSH_POS  = 26;
   localparam int BFC_ON_POS    = 25;
   localparam int BFC_AUTO_POS  = 24;
   localparam int BFC_LEVEL_MSB = 11;
   localparam int BFC_LEVEL_LSB = 0;
   localparam logic [31:0] BFC_RSV_MASK = 32'h38fff000;

   ////////////////////////////////////////////////////////////////////////////
   // values
   localparam logic [11:0] BFC_LEVEL_RST = 12'h008;
   localparam logic [11:0] BFC_LEVEL_MAX = 12'h0ff;
   localparam int          BFC_DIV8_SH   = 2;
   localparam logic [15:0] BFC_PIX8_MAX  = 16'h00ff;
   localparam logic [15:0] BFC_PIX16_MAX = 16'hffff;

   // full register word for a given level
   function automatic logic [31:0] bfc_word(input logic [11:0] level);
      logic [31:0] w;
      // [R02] [R03] [R05] [R09] bits read zero
      w = 32'h00000000;
      // [R01] presence reads one
      w[BFC_PRES_POS] = 1'b1;
      // [R04] enable reads one
      w[BFC_ON_POS]   = 1'b1;
      // [R06] level field
      w[BFC_LEVEL_MSB:BFC_LEVEL_LSB] = level;
      return w;
   endfunction

   // saturating add up to lim
   function automatic logic [15:0] bfc_sat_add(input logic [15:0] a,
                                               input logic [15:0] b,
                                               input logic [15:0] lim);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return (s > {1'b0, lim}) ? lim : s[15:0];
   endfunction

endpackage

// file: rtl/bfc_pix_if.sv
// pixel path bundle between register core and offset stage
// assumes both ends on pclk
`timescale 1ns/1ps
interface bfc_pix_if;
   logic        in_valid;
   logic [15:0] in_data;
   logic        mode16;
   logic [11:0] level;
   logic        out_valid;
   logic [15:0] out_data;

   modport core (output in_valid, in_data, mode16, level, input out_valid, out_data);
   modport proc (input in_valid, in_data, mode16, level, output out_valid, out_data);
endinterface

// file: rtl/bfc_offset.sv
// black-level offset stage: adds the brightness level (a quarter of it in 8-bit mode) to each pixel
// assumes pixels synchronous to pclk; one cycle latency, no stall
`timescale 1ns/1ps
module bfc_offset (
   input  wire logic pclk,
   input  wire logic presetn,
   bfc_pix_if.proc   pix
);

   logic [15:0] step8;
   logic [15:0] step16;

   assign step8  = {4'h0, pix.level >> bfc_pkg::BFC_DIV8_SH};
   assign step16 = {4'h0, pix.level};

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pix.out_valid <= 1'b0;
      end else begin
         pix.out_valid <= pix.in_valid;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pix.out_data <= 16'h0000;
      end else if (pix.in_valid) begin
         if (pix.mode16) begin
            // [R08] one per step
            pix.out_data <= bfc_pkg::bfc_sat_add(pix.in_data, step16,
                                                 bfc_pkg::BFC_PIX16_MAX);
         end else begin
            // [R07] one per four steps
            pix.out_data <= bfc_pkg::bfc_sat_add({8'h00, pix.in_data[7:0]}, step8,
                                                 bfc_pkg::BFC_PIX8_MAX);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_r07;
      pix.in_valid && !pix.mode16 && pix.in_data[7:0] <= 8'hc0
      |=> pix.out_data == {8'h00, $past(pix.in_data[7:0])} + {6'h00, $past(pix.level[9:2])};
   endproperty
   a_r07: assert property (p_r07) else $error("8-bit offset wrong"); // [R07]

   property p_r07_sat;
      pix.in_valid && !pix.mode16 |=> pix.out_data[15:8] == 8'h00;
   endproperty
   a_r07_sat: assert property (p_r07_sat) else $error("8-bit overflow"); // [R07]

   property p_r08;
      pix.in_valid && pix.mode16 && pix.in_data <= 16'hf000
      |=> pix.out_data == $past(pix.in_data) + {4'h0, $past(pix.level)};
   endproperty
   a_r08: assert property (p_r08) else $error("16-bit offset wrong"); // [R08]

endmodule // bfc_offset

// file: rtl/bfc_csr.sv
// brightness control/status register on APB plus pixel offset path
// assumes APB master on pclk; pixels arrive synchronous to pclk
`timescale 1ns/1ps
module bfc_csr #(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire logic              pix_in_valid,
   input  wire logic [15:0]       pix_in_data,
   input  wire logic              pix_mode16,
   output logic                   pix_out_valid,
   output logic [15:0]            pix_out_data,
   output logic [11:0]            bright_level
);

   localparam logic [ADDR_W-1:0] BR_ADDR = ADDR_W'(bfc_pkg::BFC_BRIGHT_OFF);

   logic        hit;
   logic        setup;
   logic        access;
   logic        wr_ok;
   logic [11:0] level;
   logic [11:0] next_level;

   bfc_pix_if pix ();

   ////////////////////////////////////////////////////////////////////////////
   // decode
   assign hit    = paddr[ADDR_W-1:2] == BR_ADDR[ADDR_W-1:2];
   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign pready = access;

   // byte-lane merge of the value field
   always_comb begin
      next_level = level;
      if (pstrb[0]) begin
         next_level[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
         next_level[11:8] = pwdata[11:8];
      end
   end

   // [R06] out-of-range writes dropped
   assign wr_ok = next_level <= bfc_pkg::BFC_LEVEL_MAX;

   ////////////////////////////////////////////////////////////////////////////
   // value field; flags are constants, so writes to them go nowhere
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // [R06] default level
         level <= bfc_pkg::BFC_LEVEL_RST;
      end else if (access && pwrite && hit && wr_ok) begin
         level <= next_level;
      end
   end

   // read data captured in setup phase so it stands registered in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         // [R01] fixed flags, [R09] reserved zero
         // [R02] [R03] [R04] [R05] constant flags
         prdata <= (!pwrite && hit) ? bfc_pkg::bfc_word(level) : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bright_level <= bfc_pkg::BFC_LEVEL_RST;
      end else begin
         bright_level <= level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pixel path
   assign pix.in_valid  = pix_in_valid;
   assign pix.in_data   = pix_in_data;
   assign pix.mode16    = pix_mode16;
   assign pix.level     = level;
   assign pix_out_valid = pix.out_valid;
   assign pix_out_data  = pix.out_data;

   bfc_offset u_offset (
      .pclk    (pclk),
      .presetn (presetn),
      .pix     (pix.proc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic seen_wr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_wr <= 1'b0;
      end else if (access && pwrite && hit) begin
         seen_wr <= 1'b1;
      end
   end

   sequence s_rd_setup;
      psel && !penable && !pwrite && hit;
   endsequence

   sequence s_rd_access;
      psel && penable && pready;
   endsequence

   sequence s_wr_good;
      psel && penable && pwrite && hit && wr_ok;
   endsequence

   sequence s_wr_bad;
      psel && penable && pwrite && hit && !wr_ok;
   endsequence

   property p_r01;
      s_rd_setup ##1 s_rd_access |-> prdata[bfc_pkg::BFC_PRES_POS];
   endproperty
   a_r01: assert property (p_r01) else $error("presence flag not 1"); // [R01]

   property p_r02;
      s_rd_setup |=> !prdata[bfc_pkg::BFC_ABS_POS];
   endproperty
   a_r02: assert property (p_r02) else $error("abs flag not 0"); // [R02]

   property p_r03;
      s_rd_setup |=> !prdata[bfc_pkg::BFC_PUSH_POS];
   endproperty
   a_r03: assert property (p_r03) else $error("one-push flag not 0"); // [R03]

   property p_r04;
      s_rd_setup |=> prdata[bfc_pkg::BFC_ON_POS];
   endproperty
   a_r04: assert property (p_r04) else $error("enable flag not 1"); // [R04]

   property p_r05;
      s_rd_setup |=> !prdata[bfc_pkg::BFC_AUTO_POS];
   endproperty
   a_r05: assert property (p_r05) else $error("auto flag not 0"); // [R05]

   property p_r06_rd;
      s_rd_setup |=> prdata[11:0] == $past(level);
   endproperty
   a_r06_rd: assert property (p_r06_rd) else $error("value read mismatch"); // [R06]

   property p_r06_wr;
      s_wr_good |=> level == $past(next_level) ##1 bright_level == $past(level);
   endproperty
   a_r06_wr: assert property (p_r06_wr) else $error("value write lost"); // [R06]

   property p_r06_bad;
      s_wr_bad |=> $stable(level);
   endproperty
   a_r06_bad: assert property (p_r06_bad) else $error("out-of-range stored"); // [R06]

   property p_r06_rng;
      level <= bfc_pkg::BFC_LEVEL_MAX;
   endproperty
   a_r06_rng: assert property (p_r06_rng) else $error("level out of range"); // [R06]

   property p_r06_rst;
      !seen_wr |-> level == bfc_pkg::BFC_LEVEL_RST;
   endproperty
   a_r06_rst: assert property (p_r06_rst) else $error("level not default"); // [R06]

   property p_r09;
      s_rd_setup |=> (prdata & bfc_pkg::BFC_RSV_MASK) == 32'h00000000;
   endproperty
   a_r09: assert property (p_r09) else $error("reserved bits set"); // [R09]

   property p_err;
      psel && !penable && !hit |=> pslverr && prdata == 32'h00000000;
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not flagged");

   property p_r06_hold;
      !(access && pwrite && hit) |=> $stable(level);
   endproperty
   a_r06_hold: assert property (p_r06_hold) else $error("level moved without write"); // [R06]

   property p_r06_out;
      1'b1 |=> bright_level == $past(level);
   endproperty
   a_r06_out: assert property (p_r06_out) else $error("level output lags wrong"); // [R06]

   property p_r06_hi;
      s_wr_good ##0 !pstrb[1] |=> level[11:8] == $past(level[11:8]);
   endproperty
   a_r06_hi: assert property (p_r06_hi) else $error("upper lane written unstrobed"); // [R06]

   property p_r06_lo;
      s_wr_good ##0 !pstrb[0] |=> level[7:0] == $past(level[7:0]);
   endproperty
   a_r06_lo: assert property (p_r06_lo) else $error("lower lane written unstrobed"); // [R06]

   property p_rdy;
      s_rd_setup ##1 (psel && penable) |-> pready && !pslverr;
   endproperty
   a_rdy: assert property (p_rdy) else $error("mapped read not ready at once");

endmodule // bfc_csr

// file: sim/bfc_csr_bench.sv
// self-checking bench for the brightness control register and pixel offset
// assumes bfc_csr on pclk at 100 MHz; bench acts as APB master and pixel source
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module bfc_csr_bench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        pix_in_valid;
   logic [15:0] pix_in_data;
   logic        pix_mode16;
   logic        pix_out_valid;
   logic [15:0] pix_out_data;
   logic [11:0] bright_level;
   logic [31:0] rd;
   logic        er;
   int          fail_count;
   int          n_checks;

   bfc_csr #(.ADDR_W(12)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data),
      .pix_mode16(pix_mode16), .pix_out_valid(pix_out_valid),
      .pix_out_data(pix_out_data), .bright_level(bright_level));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // expected word: msb presence and enable set, level in low twelve bits
   function automatic logic [31:0] exp_word(input logic [11:0] lvl);
      return {1'b1, 1'b0, 3'b000, 1'b0, 1'b1, 1'b0, 12'h000, lvl};
   endfunction

   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // one pixel in, checked on the following cycle
   task automatic pix(input logic m16, input logic [15:0] din, input logic [15:0] exp);
      pix_in_valid <= 1'b1;
      pix_in_data  <= din;
      pix_mode16   <= m16;
      @(posedge pclk);
      pix_in_valid <= 1'b0;
      pix_in_data  <= ~din;
      @(negedge pclk);
      `CHK(pix_out_valid, 1'b1)
      `CHK(pix_out_data, exp)
      @(negedge pclk);
      `CHK(pix_out_valid, 1'b0)
      `CHK(pix_out_data, exp)
      @(posedge pclk);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   initial begin
      #20000;
      fail_count++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [11:0] lvl;
      fail_count = 0;
      n_checks = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {pix_in_valid, pix_in_data, pix_mode16} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(bright_level, 12'h008)
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, 32'h82000008)
      `CHK(er, 1'b0)
      pix(1'b0, 16'h0010, 16'h0012);
      // flags inverted, reserved set, level at its top value
      apb(1'b1, 12'h800, 32'h7dfff0ff, 4'hf);
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, exp_word(12'h0ff))
      `CHK(bright_level, 12'h0ff)
      apb(1'b1, 12'h800, 32'h00000100, 4'hf);
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, exp_word(12'h0ff))
      pix(1'b0, 16'h0080, 16'h00bf);
      pix(1'b0, 16'h00f0, 16'h00ff);
      pix(1'b1, 16'h1000, 16'h10ff);
      pix(1'b1, 16'hff80, 16'hffff);
      // levels across one step of four
      for (int i = 0; i < 5; i++) begin
         lvl = 12'h020 + 12'(i);
         apb(1'b1, 12'h800, {20'h00000, lvl}, 4'hf);
         pix(1'b0, 16'h0010, 16'h0010 + 16'(lvl >> 2));
         pix(1'b1, 16'h1000, 16'h1000 + 16'(lvl));
      end
      // low lane only: upper value nibble keeps its old zero
      apb(1'b1, 12'h800, 32'habcdef05, 4'h1);
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, exp_word(12'h005))
      // upper lane only: lower value byte keeps its old value
      apb(1'b1, 12'h800, 32'hffff00ff, 4'h2);
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, exp_word(12'h005))
      apb(1'b1, 12'h804, 32'h00000010, 4'hf);
      `CHK(er, 1'b1)
      apb(1'b0, 12'h804, 32'h00000000, 4'hf);
      `CHK(rd, 32'h00000000)
      `CHK(er, 1'b1)
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, exp_word(12'h005))
      apb(1'b1, 12'h800, 32'h00000000, 4'hf);
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, exp_word(12'h000))
      pix(1'b0, 16'h5533, 16'h0033);
      pix(1'b1, 16'hffff, 16'hffff);
      // second reset in mid-run brings the default back
      do_reset();
      apb(1'b0, 12'h800, 32'h00000000, 4'hf);
      `CHK(rd, 32'h82000008)
      `CHK(bright_level, 12'h008)
      finish_test();
   end
endmodule // bfc_csr_bench
